// ---- rtl/dds_cfg.svh ----
// Constants for the dual DAC serial load control block
`ifndef DDS_CFG_SVH
`define DDS_CFG_SVH
`define DDS_CODE_W_WIDE     16
`define DDS_CODE_W_NARROW   14
`define DDS_ADDR_W          2
`define DDS_ADDR_NONE       2'h0
`define DDS_ADDR_A          2'h1
`define DDS_ADDR_B          2'h2
`define DDS_ADDR_BOTH       2'h3
`define DDS_PRESET_ZERO     16'h0000
`define DDS_MID_WIDE        16'h8000
`define DDS_MID_NARROW      16'h2000
`endif

// ---- rtl/dds_pkg.sv ----
// Types for the dual DAC serial load control block
package dds_pkg;
	typedef struct packed {
		logic [15:0] chan_a;
		logic [15:0] chan_b;
	} dds_pair_s;

	typedef struct packed {
		logic [1:0]  addr;
		logic [15:0] code;
	} dds_frame_s;
endpackage

// ---- rtl/dds_serial_load.sv ----
// Serial load and register control of a dual current-output DAC
`timescale 1ns/100ps
`include "dds_cfg.svh"
module dds_serial_load import dds_pkg::*; #(
	parameter int CODE_W = `DDS_CODE_W_WIDE
) (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            link_clk,
	input  wire logic            chip_sel_n,
	input  wire logic            serial_data_in,
	input  wire logic            load_dac_strobe_n,
	input  wire logic            preset_clear_n,
	input  wire logic            preset_mid,
	output dds_pair_s            input_regs,
	output dds_pair_s            dac_regs
);
	localparam int          FRAME_W   = CODE_W + `DDS_ADDR_W;
	localparam int          N_CHAN    = 2;
	localparam logic [15:0] MID_CODE  =
		(CODE_W == `DDS_CODE_W_WIDE) ? `DDS_MID_WIDE : `DDS_MID_NARROW;
	// Bits above the code width must stay clear in the narrow variant
	localparam logic [15:0] CODE_MASK = 16'((32'h1 << CODE_W) - 32'h1);

	// Only 16- and 14-bit codes have a frame layout and a mid-scale value
	if (CODE_W != `DDS_CODE_W_WIDE && CODE_W != `DDS_CODE_W_NARROW) begin : g_bad_width
		$error("CODE_W must be 16 or 14");
	end

	// Link domain: shift chain on the serial clock
	logic [FRAME_W-1:0] serial_shift_chain;

	// Surplus leading bits fall off the top, so long frames need no bit counter
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			serial_shift_chain <= '0;
		end else if (!chip_sel_n) begin
			serial_shift_chain <= {serial_shift_chain[FRAME_W-2:0], serial_data_in};
		end
	end

	// Link-domain checks look one edge back; the first edge of a run is vacuous
	property p_shift_frozen;
		@(posedge link_clk) disable iff (rst)
		$past(chip_sel_n) |-> $stable(serial_shift_chain);
	endproperty
	a_shift_frozen: assert property (p_shift_frozen)
		else $error("shift chain moved while deselected");

	property p_shift_step;
		@(posedge link_clk) disable iff (rst)
		$past(!chip_sel_n) |->
		serial_shift_chain[FRAME_W-1:1] == $past(serial_shift_chain[FRAME_W-2:0]);
	endproperty
	a_shift_step: assert property (p_shift_step)
		else $error("shift chain did not advance by one bit");

	property p_shift_direct;
		@(posedge link_clk) disable iff (rst)
		$past(!chip_sel_n) |-> serial_shift_chain[0] == $past(serial_data_in);
	endproperty
	a_shift_direct: assert property (p_shift_direct)
		else $error("data pin did not enter the chain");

	// System domain: pins pass two flops before use
	logic [2:0]  cs_sync;
	logic [1:0]  ld_sync;
	logic [1:0]  rs_sync;
	logic [1:0]  pm_sync;
	logic        cs_rise;
	logic        reset_active;
	logic        strobe_active;
	logic [15:0] preset_val;
	dds_frame_s  frame;

	// Synchronisers start at each pin's idle level, so release makes no false edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_sync <= 3'h7;
			ld_sync <= 2'h3;
			rs_sync <= 2'h3;
			pm_sync <= 2'h0;
		end else begin
			cs_sync <= {cs_sync[1:0], chip_sel_n};
			ld_sync <= {ld_sync[0], load_dac_strobe_n};
			rs_sync <= {rs_sync[0], preset_clear_n};
			pm_sync <= {pm_sync[0], preset_mid};
		end
	end

	assign cs_rise      = cs_sync[1] && !cs_sync[2];
	assign reset_active  = !rs_sync[1];
	assign strobe_active = !ld_sync[1];
	assign preset_val    = pm_sync[1] ? MID_CODE : `DDS_PRESET_ZERO;

	// The chain is quiet while select is high and the serial clock idles, so
	// reading it two cycles after the rise is a quasi-static crossing; a host
	// that lowers select and clocks again within three system cycles of the rise breaks this.
	always_comb begin
		frame.addr = serial_shift_chain[FRAME_W-1 -: 2];
		frame.code = 16'(serial_shift_chain[CODE_W-1:0]);
	end

	// One register pair per channel; index 0 is A, index 1 is B
	logic [15:0] in_word  [N_CHAN];
	logic [15:0] dac_word [N_CHAN];

	for (genvar ch = 0; ch < N_CHAN; ch++) begin : g_chan
		// Address bit ch picks this channel
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				in_word[ch] <= `DDS_PRESET_ZERO;
			end else if (reset_active) begin
				in_word[ch] <= preset_val;
			end else if (cs_rise && frame.addr[ch]) begin
				in_word[ch] <= frame.code;
			end
		end

		// Synchronised strobe trades 2-3 cycles of latency for one clock domain
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				dac_word[ch] <= `DDS_PRESET_ZERO;
			end else if (reset_active) begin
				dac_word[ch] <= preset_val;
			end else if (strobe_active) begin
				dac_word[ch] <= in_word[ch];
			end
		end
	end

	assign input_regs = {in_word[0], in_word[1]};
	assign dac_regs   = {dac_word[0], dac_word[1]};

	// Steps shared by the system-domain checks
	sequence s_load_slot;
		cs_rise && !reset_active;
	endsequence

	sequence s_follow_slot;
		strobe_active && !reset_active;
	endsequence

	sequence s_clear_slot;
		reset_active;
	endsequence

	a_load_follow: assert property (@(posedge clk) disable iff (rst)
		(!ld_sync[1] && !reset_active) |=> dac_regs == $past(input_regs))
		else $error("dac registers did not follow input registers");
	a_load_hold: assert property (@(posedge clk) disable iff (rst)
		(ld_sync[1] && !reset_active) |=> $stable(dac_regs))
		else $error("dac registers changed with strobe high");
	a_reset_preset: assert property (@(posedge clk) disable iff (rst)
		reset_active |=> dac_regs == {2{$past(preset_val)}})
		else $error("reset did not preset dac registers");
	a_reset_input: assert property (@(posedge clk) disable iff (rst)
		reset_active |=> input_regs == {2{$past(preset_val)}})
		else $error("reset did not preset input registers");
	a_addr_none: assert property (@(posedge clk) disable iff (rst)
		(cs_rise && !reset_active && frame.addr == `DDS_ADDR_NONE) |=> $stable(input_regs))
		else $error("address none changed input registers");
	a_addr_a: assert property (@(posedge clk) disable iff (rst)
		(cs_rise && !reset_active && frame.addr == `DDS_ADDR_A)
		|=> input_regs.chan_a == $past(frame.code) && $stable(input_regs.chan_b))
		else $error("channel A load wrong");
	a_addr_b: assert property (@(posedge clk) disable iff (rst)
		(cs_rise && !reset_active && frame.addr == `DDS_ADDR_B)
		|=> input_regs.chan_b == $past(frame.code) && $stable(input_regs.chan_a))
		else $error("channel B load wrong");
	a_no_rise_hold: assert property (@(posedge clk) disable iff (rst)
		(!cs_rise && !reset_active) |=> $stable(input_regs))
		else $error("input registers changed without select rise");

	property p_addr_both;
		@(posedge clk) disable iff (rst)
		(s_load_slot ##0 (frame.addr == `DDS_ADDR_BOTH))
		|=> input_regs.chan_a == $past(frame.code) && input_regs.chan_b == $past(frame.code);
	endproperty
	a_addr_both: assert property (p_addr_both)
		else $error("both channels not loaded together");

	property p_rise_single;
		@(posedge clk) disable iff (rst)
		cs_rise |=> !cs_rise;
	endproperty
	a_rise_single: assert property (p_rise_single)
		else $error("load pulse longer than one cycle");

	property p_strobe_indep;
		@(posedge clk) disable iff (rst)
		(s_load_slot ##0 strobe_active) |=> dac_regs == $past(input_regs);
	endproperty
	a_strobe_indep: assert property (p_strobe_indep)
		else $error("select rise disturbed the load strobe");

	property p_code_range_in;
		@(posedge clk) disable iff (rst)
		(input_regs.chan_a & ~CODE_MASK) == 16'h0 && (input_regs.chan_b & ~CODE_MASK) == 16'h0;
	endproperty
	a_code_range_in: assert property (p_code_range_in)
		else $error("input code wider than the code width");

	property p_code_range_dac;
		@(posedge clk) disable iff (rst)
		(dac_regs.chan_a & ~CODE_MASK) == 16'h0 && (dac_regs.chan_b & ~CODE_MASK) == 16'h0;
	endproperty
	a_code_range_dac: assert property (p_code_range_dac)
		else $error("dac code wider than the code width");

	property p_mid_preset;
		@(posedge clk) disable iff (rst)
		(s_clear_slot ##0 pm_sync[1]) |=> input_regs.chan_a == MID_CODE && dac_regs.chan_b == MID_CODE;
	endproperty
	a_mid_preset: assert property (p_mid_preset)
		else $error("mid-scale preset wrong");

	property p_zero_preset;
		@(posedge clk) disable iff (rst)
		(s_clear_slot ##0 !pm_sync[1]) |=> input_regs == 32'h0 && dac_regs == 32'h0;
	endproperty
	a_zero_preset: assert property (p_zero_preset)
		else $error("zero preset wrong");

	property p_power_zero;
		@(posedge clk)
		$past(rst) |-> input_regs == 32'h0 && dac_regs == 32'h0;
	endproperty
	a_power_zero: assert property (p_power_zero)
		else $error("registers not zero after power-on reset");

	property p_clear_over_load;
		@(posedge clk) disable iff (rst)
		(s_clear_slot ##0 cs_rise) |=> input_regs == {2{$past(preset_val)}};
	endproperty
	a_clear_over_load: assert property (p_clear_over_load)
		else $error("transfer beat the preset");

	property p_clear_over_strobe;
		@(posedge clk) disable iff (rst)
		(s_clear_slot ##0 strobe_active) |=> dac_regs == {2{$past(preset_val)}};
	endproperty
	a_clear_over_strobe: assert property (p_clear_over_strobe)
		else $error("load strobe beat the preset");

	property p_load_top_a;
		@(posedge clk) disable iff (rst)
		(s_load_slot ##0 frame.addr[0])
		|=> input_regs.chan_a == 16'($past(serial_shift_chain[CODE_W-1:0]));
	endproperty
	a_load_top_a: assert property (p_load_top_a)
		else $error("channel A code not taken from the last bits");

	property p_load_top_b;
		@(posedge clk) disable iff (rst)
		(s_load_slot ##0 frame.addr[1])
		|=> input_regs.chan_b == 16'($past(serial_shift_chain[CODE_W-1:0]));
	endproperty
	a_load_top_b: assert property (p_load_top_b)
		else $error("channel B code not taken from the last bits");

	property p_pm_apply;
		@(posedge clk) disable iff (rst)
		(s_clear_slot ##0 pm_sync[1]) |=> input_regs.chan_b == MID_CODE && dac_regs.chan_a == MID_CODE;
	endproperty
	a_pm_apply: assert property (p_pm_apply)
		else $error("preset pin ignored during reset pulse");

	property p_follow_chain;
		@(posedge clk) disable iff (rst)
		(s_follow_slot ##1 s_follow_slot) |=> dac_regs == $past(input_regs);
	endproperty
	a_follow_chain: assert property (p_follow_chain)
		else $error("dac registers stopped following");
endmodule

// ---- test/dds_host.sv ----
// Host model driving the three-wire serial link
`timescale 1ns/100ps
module dds_host;
	logic link_clk       = 1'b0;
	logic chip_sel_n     = 1'b1;
	logic serial_data_in = 1'b0;
	task automatic send(input logic [23:0] w, input int n, input int junk);
		repeat (junk) begin // Edges while deselected
			#62.5 link_clk = 1'b1;
			#62.5 link_clk = 1'b0;
		end
		chip_sel_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin // MSB first
			serial_data_in = w[i];
			#62.5 link_clk = 1'b1;
			#62.5 link_clk = 1'b0;
		end
		#62.5 chip_sel_n = 1'b1; // Link clock idle low at the rise
		serial_data_in = ~serial_data_in;
		#62.5;
	endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the dual DAC serial load block
`timescale 1ns/100ps
module tb_top import dds_pkg::*;;
	logic        clk = 1'b0, rst = 1'b0, strobe_n = 1'b1, clear_n = 1'b1, mid = 1'b0;
	dds_pair_s   in_q, dac_q, in_n, dac_n;
	logic [31:0] m_in = '0, m_dac = '0, m_nin = '0, m_ndac = '0;
	logic [17:0] sr = '0;
	int          err_total = 0, n_checks = 0, cyc = 0;
	dds_host u_host ();
	dds_serial_load #(.CODE_W(16)) u_dut (.clk(clk), .rst(rst), .link_clk(u_host.link_clk),
		.chip_sel_n(u_host.chip_sel_n), .serial_data_in(u_host.serial_data_in),
		.load_dac_strobe_n(strobe_n), .preset_clear_n(clear_n), .preset_mid(mid),
		.input_regs(in_q), .dac_regs(dac_q));
	dds_serial_load #(.CODE_W(14)) u_dut_nar (.clk(clk), .rst(rst), .link_clk(u_host.link_clk),
		.chip_sel_n(u_host.chip_sel_n), .serial_data_in(u_host.serial_data_in),
		.load_dac_strobe_n(strobe_n), .preset_clear_n(clear_n), .preset_mid(mid),
		.input_regs(in_n), .dac_regs(dac_n));
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [63:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Model keeps its own shift chain so short frames reuse stale bits
	task automatic frame(input logic [23:0] w, input int n, input int junk);
		for (int i = n - 1; i >= 0; i--) sr = {sr[16:0], w[i]};
		u_host.send(w, n, junk);
		if (sr[16]) m_in[31:16] = sr[15:0];
		if (sr[17]) m_in[15:0] = sr[15:0];
		if (sr[14]) m_nin[31:16] = {2'h0, sr[13:0]};
		if (sr[15]) m_nin[15:0] = {2'h0, sr[13:0]};
		if (!strobe_n) m_dac = m_in;
		if (!strobe_n) m_ndac = m_nin;
		check("input_regs", in_q, m_in);
		check("dac_regs", dac_q, m_dac);
		check("narrow_input_regs", in_n, m_nin);
		check("narrow_dac_regs", dac_n, m_ndac);
	endtask
	initial begin
		logic [23:0] w;
		void'($urandom(2));
		#1 rst = 1'b1;
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge clk);
		check("power_on", {in_q, dac_q}, 64'h0);
		check("power_on_narrow", {in_n, dac_n}, 64'h0);
		$display("test reset done");
		for (int k = 0; k < 16; k++) begin
			w = 24'($urandom);
			w[17:16] = 2'(k);
			frame(w, 16 + k % 9, k % 3);
		end
		$display("test frames done");
		@(posedge clk) #1 strobe_n = 1'b0;
		m_dac = m_in;
		m_ndac = m_nin;
		repeat (4) @(posedge clk);
		check("dac_follow", dac_q, m_dac);
		check("dac_follow_narrow", dac_n, m_ndac);
		frame(24'h02abcd, 18, 0);
		@(posedge clk) #1 strobe_n = 1'b1;
		frame(24'h0312ef, 18, 1);
		$display("test strobe done");
		for (int p = 0; p < 2; p++) begin
			frame(24'h035a5a, 18, 0);
			@(posedge clk) #1 mid = p[0];
			clear_n = 1'b0;
			strobe_n = 1'b0;
			repeat (4) @(posedge clk);
			m_in = p ? 32'h80008000 : 32'h0;
			m_dac = m_in;
			m_nin = p ? 32'h20002000 : 32'h0;
			m_ndac = m_nin;
			check("preset", {in_q, dac_q}, {m_in, m_dac});
			check("preset_narrow", {in_n, dac_n}, {m_nin, m_ndac});
			@(posedge clk) #1 clear_n = 1'b1;
			strobe_n = 1'b1;
		end
		$display("test preset done");
		stop_test();
	end
endmodule
